// [include/ppofc_pkg.sv]
/*
  Package for the PWM pin override and fault control stage: register
  offsets, field positions, reset values and mode codes.
  Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
*/
package ppofc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PPOFC_IO_CONTROL_OFS    = 8'h00; // Pin I/O control
  localparam logic [7:0] PPOFC_FAULT_LIMIT_OFS   = 8'h04; // Fault/limit ctl
  localparam logic [7:0] PPOFC_UNLOCK_OFS        = 8'h08; // Unlock keys
  localparam logic [7:0] PPOFC_STATUS_OFS        = 8'h0C; // Live state

  // ----------------------------------------------------------------
  // Unlock sequence keys
  // ----------------------------------------------------------------
  localparam logic [15:0] PPOFC_UNLOCK_KEY1 = 16'hABCD; // First key
  localparam logic [15:0] PPOFC_UNLOCK_KEY2 = 16'h4321; // Second key

  // ----------------------------------------------------------------
  // Pin I/O control fields
  // ----------------------------------------------------------------
  localparam int PPOFC_HIGH_OWNER_BIT   = 15;
  localparam int PPOFC_LOW_OWNER_BIT    = 14;
  localparam int PPOFC_HIGH_POL_BIT     = 13;
  localparam int PPOFC_LOW_POL_BIT      = 12;
  localparam int PPOFC_PAIR_MODE_LSB    = 10;
  localparam int PPOFC_HIGH_OVR_EN_BIT  = 9;
  localparam int PPOFC_LOW_OVR_EN_BIT   = 8;
  localparam int PPOFC_OVR_VALUE_LSB    = 6;
  localparam int PPOFC_FAULT_VALUE_LSB  = 4;
  localparam int PPOFC_LIMIT_VALUE_LSB  = 2;
  localparam int PPOFC_SWAP_BIT         = 1;
  localparam int PPOFC_OVR_ALIGN_BIT    = 0;
  localparam logic [15:0] PPOFC_IO_CONTROL_RST = 16'hC000;

  // ----------------------------------------------------------------
  // Fault/limit control fields
  // ----------------------------------------------------------------
  localparam int PPOFC_IND_FAULT_BIT    = 15;
  localparam int PPOFC_LIMIT_SRC_LSB    = 10;
  localparam int PPOFC_LIMIT_POL_BIT    = 9;
  localparam int PPOFC_LIMIT_MODE_BIT   = 8;
  localparam int PPOFC_FAULT_SRC_LSB    = 3;
  localparam int PPOFC_FAULT_POL_BIT    = 2;
  localparam int PPOFC_FAULT_MODE_LSB   = 0;
  localparam logic [15:0] PPOFC_FAULT_LIMIT_RST = 16'h00F8;
  localparam logic [4:0]  PPOFC_SRC_RESERVED    = 5'h1E;
  localparam logic [1:0]  PPOFC_FAULT_MODE_OFF  = 2'h3;

  // ----------------------------------------------------------------
  // Pair output modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PPOFC_MODE_COMPL   = 2'h0,
    PPOFC_MODE_REDUND  = 2'h1,
    PPOFC_MODE_PUSH    = 2'h2,
    PPOFC_MODE_INDEP   = 2'h3
  } ppofc_mode_type;

  // AXI response codes
  localparam logic [1:0] PPOFC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PPOFC_RESP_SLVERR = 2'h2;

endpackage : ppofc_pkg

// [verification/ppofc_pin_ctrl_chk.sv]
/*
  Checker: reset readback, pins under reset setup, read/write release.
  Assumes it is bound to ppofc_pin_ctrl and sees only its ports.
*/
`timescale 1ns/100ps
module ppofc_pin_ctrl_chk
  import ppofc_pkg::*;
#(
  parameter int NUM_SRC = 32 // Sources
) (
  input wire logic               clk_i,             // Clock
  input wire logic               rst_b_i,           // Reset
  input wire logic [7:0]         s_axi_araddr,      // Rd addr
  input wire logic               s_axi_arvalid,     // Rd req
  input wire logic               s_axi_arready,     // Rd ready
  input wire logic [31:0]        s_axi_rdata,       // Rd data
  input wire logic               s_axi_rvalid,      // Rd valid
  input wire logic               s_axi_rready,      // Rd taken
  input wire logic               s_axi_awready,     // Wr ready
  input wire logic               s_axi_wvalid,      // Wr data
  input wire logic               s_axi_wready,      // Wr ready
  input wire logic               s_axi_bvalid,      // Wr resp
  input wire logic               s_axi_bready,      // Wr taken
  input wire logic               pwm_wave_i,        // Wave
  input wire logic [NUM_SRC-1:0] fault_sources_i,   // Faults
  input wire logic               high_output_pin_o, // Pin
  input wire logic               low_output_pin_o   // Pin
);
  logic [7:0] rd_addr_reg; // Read in flight
  logic       wrote_reg;   // Reset setup no longer known
  // Any write ends the reset setup; a read keeps its address
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wrote_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wrote_reg <= 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_reg <= s_axi_araddr;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  io_reset_val_a: assert property (
    s_axi_rvalid && !wrote_reg && rd_addr_reg == PPOFC_IO_CONTROL_OFS
    |-> s_axi_rdata == {16'h0000, PPOFC_IO_CONTROL_RST})
    else $error("control reset value wrong");
  fl_reset_val_a: assert property (
    s_axi_rvalid && !wrote_reg && rd_addr_reg == PPOFC_FAULT_LIMIT_OFS
    |-> s_axi_rdata == {16'h0000, PPOFC_FAULT_LIMIT_RST})
    else $error("fault limit reset value wrong");
  // Reset setup: complementary pair, fault source 31 armed
  compl_follow_a: assert property (
    $past(rst_b_i) && !wrote_reg && !fault_sources_i[31]
    |=> high_output_pin_o == $past(pwm_wave_i)
    && low_output_pin_o == !$past(pwm_wave_i))
    else $error("pins not complementary");
  fault_force_a: assert property (
    $past(rst_b_i) && !wrote_reg && fault_sources_i[31]
    |=> !high_output_pin_o && !low_output_pin_o)
    else $error("fault values not forced");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_release_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  wr_release_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write not released");
  rd_upper_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read upper half not zero");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (fault_sources_i[31] && !wrote_reg);
endmodule : ppofc_pin_ctrl_chk
bind ppofc_pin_ctrl ppofc_pin_ctrl_chk #(.NUM_SRC(NUM_SRC))
  u_ppofc_pin_ctrl_chk (.*);

// [verification/ppofc_power_stage.sv]
/*
  Power stage model: gate drivers latching both pin levels.
  Assumes the pins are registered on clk_i.
*/
`timescale 1ns/100ps
module ppofc_power_stage (
  input  wire logic       clk_i,  // Clock
  input  wire logic       high_i, // High gate
  input  wire logic       low_i,  // Low gate
  output logic [1:0]      phase_o // Latched high, low
);
  // Drivers add one cycle of delay, as a real stage would
  always_ff @(posedge clk_i) begin
    phase_o <= {high_i, low_i};
  end
endmodule : ppofc_power_stage

// [verification/test_pwm_pin_override_fault_ctrl.sv]
/*
  Bench: bus tasks, reset values, pair modes, forcing order, lock.
  Assumes design, stage model and checker are compiled first.
*/
`timescale 1ns/100ps
module test_pwm_pin_override_fault_ctrl;
  import ppofc_pkg::*;
  logic clk_i = 0, rst_b_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic write_lock_config_i = 0, pwm_wave_i = 0, pwm_wave_low_i = 0;
  logic period_start_i = 0, gpio_high_i = 0, gpio_low_i = 0;
  logic module_enable_i = 0; // Held off: modes and polarities change
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, high_output_pin_o, low_output_pin_o;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [31:0] fault_sources_i = 0, limit_sources_i = 0;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic [1:0]  s_axi_bresp, s_axi_rresp, phase;
  int fail_count = 0, samples_checked = 0;
  always #2.5 clk_i = ~clk_i;
  ppofc_pin_ctrl u_ppofc_pin_ctrl (.*);
  ppofc_power_stage u_ppofc_power_stage (.clk_i, .high_i(high_output_pin_o),
    .low_i(low_output_pin_o), .phase_o(phase));
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [33:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
    if (what == "wait") close_out();
  endtask : chk
  // Write: both halves offered at once, released as each is taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic [1:0] er);
    logic ha, hw, hb = 0;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (int n = 0; n < 40 && !hb; n++) begin
      @(negedge clk_i);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk_i);
      if (ha) s_axi_awvalid <= 0;
      if (hw) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    if (!hb) chk("wait", 34'h1, 34'h0);
    chk("bresp", {32'h0, r}, {32'h0, er});
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ha, hr = 0;
    logic [33:0] got;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (int n = 0; n < 40 && !hr; n++) begin
      @(negedge clk_i);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      got = {s_axi_rresp, s_axi_rdata};
      @(posedge clk_i);
      if (ha) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    if (!hr) chk("wait", 34'h1, 34'h0);
    chk("read", got, {er, e});
    @(posedge clk_i);
  endtask : rd
  // Pins settle one edge after inputs, the stage one edge later
  task automatic pins(input logic [1:0] e);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("pins", {32'h0, phase}, {32'h0, e});
    @(posedge clk_i);
  endtask : pins
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1;
    @(posedge clk_i);
    rd(PPOFC_IO_CONTROL_OFS, 32'hC000, PPOFC_RESP_OKAY);
    rd(PPOFC_FAULT_LIMIT_OFS, 32'h00F8, PPOFC_RESP_OKAY);
    rd(8'h10, 32'h0, PPOFC_RESP_SLVERR);
    pwm_wave_i <= 1;
    pins(2'b10);
    pwm_wave_i <= 0;
    pins(2'b01);
    fault_sources_i <= 32'h80000000;
    pins(2'b00);
    fault_sources_i <= 0;
    $display("test reset setup done");
    pwm_wave_i <= 1;
    pwm_wave_low_i <= 1;
    for (int m = 0; m < 4; m++) begin
      wr(PPOFC_IO_CONTROL_OFS, 16'hC000 | 16'(m << 10), PPOFC_RESP_OKAY);
      pins({1'b1, m[0]});
    end
    wr(PPOFC_IO_CONTROL_OFS, 16'hC800, PPOFC_RESP_OKAY);
    period_start_i <= 1;
    @(posedge clk_i);
    period_start_i <= 0;
    pins(2'b01);
    wr(PPOFC_IO_CONTROL_OFS, 16'hF400, PPOFC_RESP_OKAY);
    pins(2'b00);
    $display("test pair modes done");
    wr(PPOFC_IO_CONTROL_OFS, 16'hC390, PPOFC_RESP_OKAY);
    pins(2'b10);
    fault_sources_i <= 32'h80000000;
    pins(2'b01);
    wr(PPOFC_FAULT_LIMIT_OFS, 16'h17FB, PPOFC_RESP_OKAY);
    wr(PPOFC_IO_CONTROL_OFS, 16'hC39C, PPOFC_RESP_OKAY);
    pins(2'b11);
    limit_sources_i <= 32'h20;
    pins(2'b10);
    limit_sources_i <= 0;
    wr(PPOFC_FAULT_LIMIT_OFS, 16'h7BFB, PPOFC_RESP_OKAY);
    pins(2'b10);
    wr(PPOFC_FAULT_LIMIT_OFS, 16'h96FB, PPOFC_RESP_OKAY);
    pins(2'b10);
    rd(PPOFC_FAULT_LIMIT_OFS, 32'h96FB, PPOFC_RESP_OKAY);
    rd(PPOFC_STATUS_OFS, 32'h27, PPOFC_RESP_OKAY);
    wr(PPOFC_IO_CONTROL_OFS, 16'hC35D, PPOFC_RESP_OKAY);
    pins(2'b10);
    period_start_i <= 1;
    @(posedge clk_i);
    period_start_i <= 0;
    pins(2'b01);
    $display("test forcing done");
    write_lock_config_i <= 1;
    wr(PPOFC_IO_CONTROL_OFS, 16'h0000, PPOFC_RESP_OKAY);
    rd(PPOFC_IO_CONTROL_OFS, 32'hC35D, PPOFC_RESP_OKAY);
    wr(PPOFC_UNLOCK_OFS, PPOFC_UNLOCK_KEY1, PPOFC_RESP_OKAY);
    wr(PPOFC_UNLOCK_OFS, PPOFC_UNLOCK_KEY2, PPOFC_RESP_OKAY);
    gpio_high_i <= 1;
    wr(PPOFC_IO_CONTROL_OFS, 16'h0030, PPOFC_RESP_OKAY);
    pins(2'b10);
    rd(PPOFC_IO_CONTROL_OFS, 32'h0030, PPOFC_RESP_OKAY);
    wr(8'h10, 16'hFFFF, PPOFC_RESP_SLVERR);
    $display("test lock done");
    close_out();
  end
endmodule : test_pwm_pin_override_fault_ctrl

// [verilog/ppofc_pin_ctrl.sv]
/*
  Output-pin control stage of one PWM generator: pin ownership,
  polarity, pair mode, override, fault and current-limit forcing, with
  both control registers on an AXI4-Lite slave and a write lock on the pin I/O control register.
  Assumes the generator waveform, period strobe, fault and limit source
  vectors and the module enable are synchronous to clk_i.
*/
`timescale 1ns/100ps

module ppofc_pin_ctrl
  import ppofc_pkg::*;
#(
  parameter int NUM_SRC = 32                   // Fault/limit sources
) (
  input  wire logic               clk_i,       // 200 MHz clock
  input  wire logic               rst_b_i,     // Sync reset, active low
  // AXI4-Lite slave
  input  wire logic [7:0]         s_axi_awaddr,  // Write address
  input  wire logic               s_axi_awvalid, // Write address valid
  output logic                    s_axi_awready, // Write address ready
  input  wire logic [31:0]        s_axi_wdata,   // Write data
  input  wire logic [3:0]         s_axi_wstrb,   // Byte enables
  input  wire logic               s_axi_wvalid,  // Write data valid
  output logic                    s_axi_wready,  // Write data ready
  output logic [1:0]              s_axi_bresp,   // Write response
  output logic                    s_axi_bvalid,  // Write response valid
  input  wire logic               s_axi_bready,  // Write response ready
  input  wire logic [7:0]         s_axi_araddr,  // Read address
  input  wire logic               s_axi_arvalid, // Read address valid
  output logic                    s_axi_arready, // Read address ready
  output logic [31:0]             s_axi_rdata,   // Read data
  output logic [1:0]              s_axi_rresp,   // Read response
  output logic                    s_axi_rvalid,  // Read data valid
  input  wire logic               s_axi_rready,  // Read data ready
  // Generator and system side
  input  wire logic               write_lock_config_i, // Lock strap
  input  wire logic               module_enable_i, // Module running
  input  wire logic               pwm_wave_i,    // Generator waveform
  input  wire logic               pwm_wave_low_i, // Independent low wave
  input  wire logic               period_start_i, // Period boundary pulse
  input  wire logic [NUM_SRC-1:0] fault_sources_i, // Fault inputs
  input  wire logic [NUM_SRC-1:0] limit_sources_i, // Limit inputs
  input  wire logic               gpio_high_i,   // GPIO value, high pin
  input  wire logic               gpio_low_i,    // GPIO value, low pin
  // Pins
  output logic                    high_output_pin_o, // High pin
  output logic                    low_output_pin_o   // Low pin
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] io_ctl_reg, io_ctl_next;      // Pin I/O control
  logic [15:0] fl_ctl_reg, fl_ctl_next;      // Fault/limit control
  logic [1:0]  unlock_reg, unlock_next;      // Unlock sequence stage
  logic        aw_got_reg, aw_got_next;      // Address captured
  logic        w_got_reg, w_got_next;        // Data captured
  logic [7:0]  aw_addr_reg, aw_addr_next;    // Captured address
  logic [31:0] w_data_reg, w_data_next;      // Captured data
  logic [3:0]  w_strb_reg, w_strb_next;      // Captured strobes
  logic        bvalid_reg, bvalid_next;      // Write response pending
  logic [1:0]  bresp_reg, bresp_next;        // Write response code
  logic        rvalid_reg, rvalid_next;      // Read data pending
  logic [31:0] rdata_reg, rdata_next;        // Read data
  logic [1:0]  rresp_reg, rresp_next;        // Read response code
  logic        push_sel_reg, push_sel_next;  // Push-pull pin in turn
  logic        high_pin_reg, high_pin_next;  // High pin flop
  logic        low_pin_reg, low_pin_next;    // Low pin flop
  logic [1:0]  ovr_shadow_reg, ovr_shadow_next; // Aligned override data
  logic [1:0]  ovr_en_shadow_reg, ovr_en_shadow_next; // Aligned enables

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Merge a 32-bit write into a 16-bit register under byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // Choose the driven value of one pin in priority order
  function automatic logic pick_pin(input logic fault_on, input logic fv,
                                    input logic limit_on, input logic lv,
                                    input logic ovr_on, input logic ov,
                                    input logic wave, input logic pol);
    logic v;
    v = wave;
    if (fault_on) begin
      v = fv;
    end else if (limit_on) begin
      v = lv;
    end else if (ovr_on) begin
      v = ov;
    end
    return v ^ pol;
  endfunction : pick_pin

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  ppofc_mode_type pair_output_mode;            // Pair mode
  logic fault_active;                          // Selected fault live
  logic limit_active;                          // Selected limit live
  logic fault_force;                           // Fault forcing pins
  logic limit_force;                           // Limit forcing pins
  logic independent_fault_enable;              // Independent fault mode

  assign pair_output_mode = ppofc_mode_type'(
    io_ctl_reg[PPOFC_PAIR_MODE_LSB +: 2]);
  assign independent_fault_enable = fl_ctl_reg[PPOFC_IND_FAULT_BIT];

  // Fault source with its polarity
  ppofc_source_select #(.NUM_SRC(NUM_SRC)) u_fault_sel (
    .sources_i    (fault_sources_i),
    .select_i     (fl_ctl_reg[PPOFC_FAULT_SRC_LSB +: 5]),
    .active_low_i (fl_ctl_reg[PPOFC_FAULT_POL_BIT]),
    .reserved_i   (PPOFC_SRC_RESERVED),
    .active_o     (fault_active)
  );

  // Limit source with its polarity
  ppofc_source_select #(.NUM_SRC(NUM_SRC)) u_limit_sel (
    .sources_i    (limit_sources_i),
    .select_i     (fl_ctl_reg[PPOFC_LIMIT_SRC_LSB +: 5]),
    .active_low_i (fl_ctl_reg[PPOFC_LIMIT_POL_BIT]),
    .reserved_i   (PPOFC_SRC_RESERVED),
    .active_o     (limit_active)
  );

  // Fault mode code 3 is off; other codes force the pins
  assign fault_force = fault_active &&
    (fl_ctl_reg[PPOFC_FAULT_MODE_LSB +: 2] != PPOFC_FAULT_MODE_OFF);
  assign limit_force = limit_active && fl_ctl_reg[PPOFC_LIMIT_MODE_BIT];

  // ----------------------------------------------------------------
  // AXI4-Lite slave and register writes
  // ----------------------------------------------------------------
  // Address and data are taken in either order; one write at a time
  always_comb begin
    logic        locked;
    logic [15:0] wd16;
    locked       = 1'b0;
    wd16         = 16'h0000;
    io_ctl_next  = io_ctl_reg;
    fl_ctl_next  = fl_ctl_reg;
    unlock_next  = unlock_reg;
    aw_got_next  = aw_got_reg;
    w_got_next   = w_got_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_next  = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_next  = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Perform the write once both halves are held and no response waits
    if (aw_got_reg && w_got_reg && !bvalid_reg) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = PPOFC_RESP_OKAY;
      wd16        = w_data_reg[15:0];
      // Lock strap checked each write so it may change with config
      locked      = write_lock_config_i && (unlock_reg != 2'h2);
      case (aw_addr_reg)
        PPOFC_IO_CONTROL_OFS: begin
          if (!locked) begin
            io_ctl_next = merge16(io_ctl_reg, w_data_reg, w_strb_reg);
          end
          unlock_next = 2'h0;    // One unlock covers one write
        end
        PPOFC_FAULT_LIMIT_OFS: begin
          fl_ctl_next = merge16(fl_ctl_reg, w_data_reg, w_strb_reg);
        end
        PPOFC_UNLOCK_OFS: begin
          // Two keys in order arm the next control write
          if (wd16 == PPOFC_UNLOCK_KEY1) begin
            unlock_next = 2'h1;
          end else if (wd16 == PPOFC_UNLOCK_KEY2 && unlock_reg == 2'h1) begin
            unlock_next = 2'h2;
          end else begin
            unlock_next = 2'h0;
          end
        end
        PPOFC_STATUS_OFS: begin
          // Read-only; write is accepted and dropped
        end
        default: begin
          bresp_next = PPOFC_RESP_SLVERR;
        end
      endcase
    end
  end

  // Ready while the half is not yet held
  assign s_axi_awready = !aw_got_reg;
  assign s_axi_wready  = !w_got_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // Reads answer one cycle after the address is taken
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = PPOFC_RESP_OKAY;
      case (s_axi_araddr)
        PPOFC_IO_CONTROL_OFS:  rdata_next = {16'h0000, io_ctl_reg};
        PPOFC_FAULT_LIMIT_OFS: rdata_next = {16'h0000, fl_ctl_reg};
        PPOFC_UNLOCK_OFS:      rdata_next = {30'h0, unlock_reg};
        PPOFC_STATUS_OFS: begin
          rdata_next = {26'h0, push_sel_reg, limit_force,
                        fault_force, limit_active, fault_active,
                        independent_fault_enable};
        end
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = PPOFC_RESP_SLVERR;
        end
      endcase
    end
  end

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ----------------------------------------------------------------
  // Pin datapath
  // ----------------------------------------------------------------
  // Source waveforms from the pair mode, then forcing, then polarity.
  // Pair mode is sampled live; changing it while enabled glitches pins.
  always_comb begin
    logic wave_h;
    logic wave_l;
    logic ovr_h;
    logic ovr_l;
    wave_h = pwm_wave_i;
    wave_l = ~pwm_wave_i;
    ovr_h = io_ctl_reg[PPOFC_OVR_ALIGN_BIT] ? ovr_en_shadow_reg[1]
                                           : io_ctl_reg[PPOFC_HIGH_OVR_EN_BIT];
    ovr_l = io_ctl_reg[PPOFC_OVR_ALIGN_BIT] ? ovr_en_shadow_reg[0]
                                           : io_ctl_reg[PPOFC_LOW_OVR_EN_BIT];
    push_sel_next = push_sel_reg;
    if (period_start_i) begin
      push_sel_next = ~push_sel_reg;
    end
    case (pair_output_mode)
      PPOFC_MODE_COMPL: begin
        wave_l = ~pwm_wave_i;
      end
      PPOFC_MODE_REDUND: begin
        wave_l = pwm_wave_i;
      end
      PPOFC_MODE_PUSH: begin
        wave_h = pwm_wave_i & ~push_sel_reg;
        wave_l = pwm_wave_i & push_sel_reg;
      end
      PPOFC_MODE_INDEP: begin
        wave_l = pwm_wave_low_i;
      end
      default: begin
        wave_l = ~pwm_wave_i;
      end
    endcase
    // Override may be aligned to the period boundary
    ovr_shadow_next    = ovr_shadow_reg;
    ovr_en_shadow_next = ovr_en_shadow_reg;
    if (!io_ctl_reg[PPOFC_OVR_ALIGN_BIT] || period_start_i) begin
      ovr_shadow_next    = io_ctl_reg[PPOFC_OVR_VALUE_LSB +: 2];
      ovr_en_shadow_next = {io_ctl_reg[PPOFC_HIGH_OVR_EN_BIT],
                            io_ctl_reg[PPOFC_LOW_OVR_EN_BIT]};
    end
    // Fault forcing hits both pins
    high_pin_next = pick_pin(fault_force,
      io_ctl_reg[PPOFC_FAULT_VALUE_LSB + 1], limit_force,
      io_ctl_reg[PPOFC_LIMIT_VALUE_LSB + 1], ovr_h,
      io_ctl_reg[PPOFC_OVR_ALIGN_BIT] ? ovr_shadow_reg[1]
                                      : io_ctl_reg[PPOFC_OVR_VALUE_LSB + 1],
      wave_h, io_ctl_reg[PPOFC_HIGH_POL_BIT]);
    low_pin_next = pick_pin(fault_force,
      io_ctl_reg[PPOFC_FAULT_VALUE_LSB], limit_force,
      io_ctl_reg[PPOFC_LIMIT_VALUE_LSB], ovr_l,
      io_ctl_reg[PPOFC_OVR_ALIGN_BIT] ? ovr_shadow_reg[0]
                                      : io_ctl_reg[PPOFC_OVR_VALUE_LSB],
      wave_l, io_ctl_reg[PPOFC_LOW_POL_BIT]);
    // GPIO takes a pin the generator does not own
    if (!io_ctl_reg[PPOFC_HIGH_OWNER_BIT]) begin
      high_pin_next = gpio_high_i;
    end
    if (!io_ctl_reg[PPOFC_LOW_OWNER_BIT]) begin
      low_pin_next = gpio_low_i;
    end
  end

  assign high_output_pin_o = high_pin_reg;
  assign low_output_pin_o  = low_pin_reg;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset; all control state to documented values
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      io_ctl_reg        <= PPOFC_IO_CONTROL_RST;
      fl_ctl_reg        <= PPOFC_FAULT_LIMIT_RST;
      unlock_reg        <= 2'h0;
      aw_got_reg        <= 1'b0;
      w_got_reg         <= 1'b0;
      aw_addr_reg       <= 8'h00;
      w_data_reg        <= 32'h00000000;
      w_strb_reg        <= 4'h0;
      bvalid_reg        <= 1'b0;
      bresp_reg         <= PPOFC_RESP_OKAY;
      rvalid_reg        <= 1'b0;
      rdata_reg         <= 32'h00000000;
      rresp_reg         <= PPOFC_RESP_OKAY;
      push_sel_reg      <= 1'b0;
      high_pin_reg      <= 1'b0;
      low_pin_reg       <= 1'b0;
      ovr_shadow_reg    <= 2'h0;
      ovr_en_shadow_reg <= 2'h0;
    end else begin
      io_ctl_reg        <= io_ctl_next;
      fl_ctl_reg        <= fl_ctl_next;
      unlock_reg        <= unlock_next;
      aw_got_reg        <= aw_got_next;
      w_got_reg         <= w_got_next;
      aw_addr_reg       <= aw_addr_next;
      w_data_reg        <= w_data_next;
      w_strb_reg        <= w_strb_next;
      bvalid_reg        <= bvalid_next;
      bresp_reg         <= bresp_next;
      rvalid_reg        <= rvalid_next;
      rdata_reg         <= rdata_next;
      rresp_reg         <= rresp_next;
      push_sel_reg      <= push_sel_next;
      high_pin_reg      <= high_pin_next;
      low_pin_reg       <= low_pin_next;
      ovr_shadow_reg    <= ovr_shadow_next;
      ovr_en_shadow_reg <= ovr_en_shadow_next;
    end
  end

endmodule : ppofc_pin_ctrl

// [verilog/ppofc_source_select.sv]
/*
  Picks one control signal out of a source vector by a five-bit code,
  applies polarity and holds the output low when the code names no valid source.
  Assumes sources are synchronous to the block clock.
*/
`timescale 1ns/100ps
module ppofc_source_select #(
  parameter int NUM_SRC = 32                  // Width of source vector
) (
  input  wire logic [NUM_SRC-1:0] sources_i,  // Candidate signals
  input  wire logic [4:0]         select_i,   // Source code
  input  wire logic               active_low_i, // Polarity
  input  wire logic [4:0]         reserved_i, // Code with no source
  output logic                    active_o    // Selected, polarity fixed
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Reserved or out-of-range codes never assert
  always_comb begin
    if (select_i == reserved_i || int'(select_i) >= NUM_SRC) begin
      active_o = 1'b0;
    end else begin
      active_o = sources_i[select_i] ^ active_low_i;
    end
  end

endmodule : ppofc_source_select
